// File: hw/ccds_core.sv
// Purpose: digital core of a closed-caption data slicer with an AHB-Lite register slave
// Assumes: hclk is the pll clock locked to hsync; all pin inputs are synchronous to hclk
// Notes: analog comparators and clamp live outside; this core drives their controls
//
// Functional notes
// - Bit sampling is timed by the pll clock locked to horizontal sync.
// - Check parity, store characters in registers, set flag, optional interrupt.
// - Search exactly one programmable line, 14 through 29.
// - Extract in both fields; status bit tells which field data came from.
// - Any status register write clears the data-sampled flag.
// - Each character byte holds a 7-bit code plus a parity error bit.
// - Parity error set on non-odd parity; cleared by status write or reset.
// - Data bits shift in LSB first, read-only, unchanged by reset.
// - Interrupt enable bit 7 of control one gates the flag; reset clears.
// - Slicer enable turns on reference and clocks logic; pll must be on.
// - With verify set, missing vsync in blanking aborts extraction.
// - Four-bit line select: target line is 14 plus code; reset clears.
// - Clamp-disable bit 0 writable only in test mode; drives clamp control in test mode only.
// - Composite sync finds blanking, gates clamp, field, overrun, target line.
// - Vsync is active high; validates blanking and generates field info.
// - Sliced data gives run-in clock, start bit and data bit samples.
// - Two-bit run-in counter of data rising edges, saturates at three, readable.
// - Vertical-pulse-seen bit stays clear on short pulses, no vsync, early line.
// - Status bit shows live separated sync.
// - Overrun set when extraction starts with flag still set; no interrupt.
// - Run-in window 8 us wide, 24 us after line sync; counter cleared by write.
// - Pulse width code selects 8, 10, 12 or 14 us minimum vertical pulse.
// - Vsync delay bit delays vsync by a fixed 12 us before field detection.
`timescale 1ns/1ps
module ccds_core
  import ccds_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sync_sliced,
  input wire logic data_sliced,
  input wire logic vsync,
  input wire logic hsync_pll,
  input wire logic pll_enable,
  input wire logic slicer_test_mode,
  output logic sample_irq,
  output logic slice_ref_on,
  output logic [1:0] slice_level,
  output logic clamp_off,
  output logic display_field
);

  // register decode on the word index, used for both read and write paths
  function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] idx);
    reg_hit = (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction : reg_hit

  // minimum vertical pulse width in cycles for a given code
  function automatic logic [PWC_W-1:0] pw_cycles(input logic [1:0] code);
    pw_cycles = PWC_W'((PW_BASE_NS + int'(code) * PW_STEP_NS) / CLK_PERIOD_NS);
  endfunction : pw_cycles

  logic [7:0] ctrl_one_r;
  logic [7:0] ctrl_two_r;
  logic data_sampled_flag_r;
  logic overrun_flag_r;
  logic first_field_indicator_r;
  logic vertical_pulse_seen_r;
  logic [1:0] runin_cnt_r;
  logic [6:0] code_first_r;
  logic [6:0] code_second_r;
  logic pe_first_r;
  logic pe_second_r;
  logic wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic irq_r;
  logic ref_on_r;
  logic clamp_off_r;
  logic display_field_r;
  logic vsync_r;
  logic hsync_r;
  logic sync_r;
  logic data_r;
  logic [PWC_W-1:0] pw_cnt_r;
  logic [PWC_W-1:0] vsd_cnt_r;
  logic vsd_busy_r;
  logic vblank_r;
  logic field_now_r;
  ccds_state_t state_r;
  ccds_state_t state_nxt;
  logic [4:0] line_cnt_r;
  logic [TMR_W-1:0] tmr_r;
  logic [15:0] shift_r;
  logic [4:0] bit_cnt_r;

  // bus address phase and write decode
  wire addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire rd_take = addr_phase && !hwrite;
  wire wr_c1 = wr_pend_r && reg_hit(wr_addr_r, IDX_CTRL_ONE);
  wire wr_c2 = wr_pend_r && reg_hit(wr_addr_r, IDX_CTRL_TWO);
  wire wr_sr = wr_pend_r && reg_hit(wr_addr_r, IDX_STATUS);

  // control fields
  wire irq_en = ctrl_one_r[C1_IRQ_EN];
  wire active = ctrl_one_r[C1_ENABLE] && pll_enable;
  wire vverify = ctrl_one_r[C1_VVERIFY];
  wire [3:0] line_sel = ctrl_one_r[C1_LINE_LSB +: 4];
  wire [4:0] target_line = FIRST_TARGET_LINE + {1'b0, line_sel};
  wire [1:0] pw_code = ctrl_two_r[C2_PW_LSB +: 2];
  wire vdelay = ctrl_two_r[C2_VDELAY];

  // input edges; inputs are already synchronous so one flop suffices
  wire vsync_rise = vsync && !vsync_r;
  wire hsync_rise = hsync_pll && !hsync_r;
  wire sync_rise = sync_sliced && !sync_r;
  wire data_rise = data_sliced && !data_r;

  // wide pulse: separated sync held high for the programmed minimum width
  wire vp_hit = sync_sliced && (pw_cnt_r == pw_cycles(pw_code) - PWC_W'(1));

  // vsync as seen by field detection, optionally delayed
  wire vs_dly_done = vsd_busy_r && (vsd_cnt_r == PWC_W'(VS_DELAY_CYC - 1));
  wire vs_event = vdelay ? vs_dly_done : vsync_rise;

  // window for vsync to validate the field: after wide pulse, before the line above target
  wire vs_window = (state_r == CCDS_S_LINE) && (line_cnt_r < target_line - 5'h01);
  wire reach_line = (state_r == CCDS_S_LINE) && hsync_rise && (line_cnt_r + 5'h01 == target_line);
  wire abort_line = reach_line && vverify && !vertical_pulse_seen_r;
  wire begin_extract = reach_line && !abort_line;
  wire tmr_end_delay = (tmr_r == TMR_W'(RUNIN_DELAY_CYC - 1));
  wire tmr_end_win = (tmr_r == TMR_W'(RUNIN_WIN_CYC - 1));
  wire tmr_end_start = (tmr_r == TMR_W'(START_TMO_CYC - 1));
  wire tmr_end_first = (tmr_r == TMR_W'(FIRST_SAMPLE_CYC - 1));
  wire tmr_end_bit = (tmr_r == TMR_W'(BIT_CYC - 1));
  wire sample_now = (state_r == CCDS_S_BITS) && ((bit_cnt_r == 5'h00) ? tmr_end_first : tmr_end_bit);
  wire last_bit = sample_now && (bit_cnt_r == FRAME_BITS - 5'h01);
  wire [15:0] frame = {data_sliced, shift_r[15:1]};
  wire frame_done = last_bit;

  // odd parity check over each received byte including its parity bit
  wire pe_a = ~^frame[7:0];
  wire pe_b = ~^frame[15:8];

  // sequence of one field: line count, sync edge, run-in delay, window, start, bits
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CCDS_S_VWAIT: begin
        if (vp_hit) begin
          state_nxt = CCDS_S_LINE;
        end
      end
      CCDS_S_LINE: begin
        if (abort_line) begin
          state_nxt = CCDS_S_VWAIT;
        end else if (begin_extract) begin
          state_nxt = CCDS_S_SYNCW;
        end
      end
      CCDS_S_SYNCW: begin
        if (sync_rise) begin
          state_nxt = CCDS_S_DELAY;
        end
      end
      CCDS_S_DELAY: begin
        if (tmr_end_delay) begin
          state_nxt = CCDS_S_RUNIN;
        end
      end
      CCDS_S_RUNIN: begin
        if (tmr_end_win) begin
          state_nxt = CCDS_S_START;
        end
      end
      CCDS_S_START: begin
        if (data_rise) begin
          state_nxt = CCDS_S_BITS;
        end else if (tmr_end_start) begin
          state_nxt = CCDS_S_VWAIT;
        end
      end
      CCDS_S_BITS: begin
        if (frame_done) begin
          state_nxt = CCDS_S_VWAIT;
        end
      end
      default: state_nxt = CCDS_S_VWAIT;
    endcase
  end

  // sequencer state; disabling the slicer parks it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= CCDS_S_VWAIT;
    end else if (!active) begin
      state_r <= CCDS_S_VWAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // shared timer restarts on every state change so each phase counts from zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r || sample_now) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + TMR_W'(1);
    end
  end

  // line counter: wide pulses pin it to the vertical pulse line, pll hsync advances it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_cnt_r <= '0;
    end else if (vp_hit && (state_r == CCDS_S_VWAIT || state_r == CCDS_S_LINE)) begin
      line_cnt_r <= VP_LINE;
    end else if (state_r == CCDS_S_LINE && hsync_rise) begin
      line_cnt_r <= line_cnt_r + 5'h01;
    end
  end

  // vertical blanking flag gates the input clamp
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vblank_r <= 1'b0;
    end else if (vp_hit && active) begin
      vblank_r <= 1'b1;
    end else if (line_cnt_r >= VBLANK_END_LINE || state_r == CCDS_S_VWAIT) begin
      vblank_r <= 1'b0;
    end
  end

  // input sampling for edges and pulse width measure
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vsync_r <= 1'b0;
      hsync_r <= 1'b0;
      sync_r <= 1'b0;
      data_r <= 1'b0;
      pw_cnt_r <= '0;
    end else begin
      vsync_r <= vsync;
      hsync_r <= hsync_pll;
      sync_r <= sync_sliced;
      data_r <= data_sliced;
      pw_cnt_r <= (sync_sliced && !vp_hit) ? pw_cnt_r + PWC_W'(1) : '0;
    end
  end

  // vsync delay line; a new edge during a running delay is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vsd_busy_r <= 1'b0;
      vsd_cnt_r <= '0;
    end else if (vs_dly_done) begin
      vsd_busy_r <= 1'b0;
      vsd_cnt_r <= '0;
    end else if (vsd_busy_r) begin
      vsd_cnt_r <= vsd_cnt_r + PWC_W'(1);
    end else if (vsync_rise && vdelay) begin
      vsd_busy_r <= 1'b1;
    end
  end

  // field from the half-line offset of vsync against pll hsync
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      field_now_r <= 1'b0;
    end else if (vs_event && active) begin
      field_now_r <= hsync_pll;
    end
  end

  // vsync validation of the current field; cleared by a wide pulse seen in CCDS_S_VWAIT
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vertical_pulse_seen_r <= 1'b0;
    end else if (vp_hit && state_r == CCDS_S_VWAIT) begin
      vertical_pulse_seen_r <= 1'b0;
    end else if (vs_event && vs_window) begin
      vertical_pulse_seen_r <= 1'b1;
    end
  end

  // bit shifter, lsb first; samples at mid-bit from the start edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r <= '0;
      bit_cnt_r <= '0;
    end else if (state_r != CCDS_S_BITS) begin
      bit_cnt_r <= '0;
    end else if (sample_now) begin
      shift_r <= frame;
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // character codes hold through reset, so no reset branch here
  always_ff @(posedge hclk) begin
    if (frame_done) begin
      code_first_r <= frame[6:0];
      code_second_r <= frame[14:8];
    end
  end

  // run-in counter: a write clears, but a same-cycle edge still counts
  wire [1:0] runin_base = wr_sr ? 2'h0 : runin_cnt_r;
  wire runin_inc = (state_r == CCDS_S_RUNIN) && data_rise && (runin_base != RUNIN_SAT);

  // status flags: hardware set wins over a status register write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_sampled_flag_r <= 1'b0;
      overrun_flag_r <= 1'b0;
      pe_first_r <= 1'b0;
      pe_second_r <= 1'b0;
      first_field_indicator_r <= 1'b0;
      runin_cnt_r <= '0;
    end else begin
      data_sampled_flag_r <= frame_done || (data_sampled_flag_r && !wr_sr);
      overrun_flag_r <= (begin_extract && data_sampled_flag_r)
                        || (overrun_flag_r && !wr_sr);
      pe_first_r <= frame_done ? pe_a : (pe_first_r && !wr_sr);
      pe_second_r <= frame_done ? pe_b : (pe_second_r && !wr_sr);
      runin_cnt_r <= runin_base + {1'b0, runin_inc};
      if (frame_done) begin
        first_field_indicator_r <= field_now_r;
      end
    end
  end

  // control registers; the clamp bit only takes writes in test mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_one_r <= CTRL_ONE_RST;
      ctrl_two_r <= CTRL_TWO_RST;
    end else begin
      if (wr_c1) begin
        ctrl_one_r[7:1] <= hwdata[7:1];
        if (slicer_test_mode) begin
          ctrl_one_r[C1_CLAMP] <= hwdata[C1_CLAMP];
        end
      end
      if (wr_c2) begin
        ctrl_two_r[7:3] <= hwdata[7:3];
      end
    end
  end

  // read mux; comparator mirrors only show in test mode, unmapped reads zero
  wire [7:0] status_val = {data_sampled_flag_r, overrun_flag_r, first_field_indicator_r,
                           sync_sliced, vertical_pulse_seen_r, 1'b0, runin_cnt_r};
  wire [2:0] cmp_mirror = slicer_test_mode ? {sync_sliced, data_sliced, vblank_r} : 3'h0;
  wire [7:0] c1_read = {ctrl_one_r[7:1], slicer_test_mode & ctrl_one_r[C1_CLAMP]};
  wire [7:0] rd_byte = reg_hit(haddr, IDX_CHAR_FIRST) ? {pe_first_r, code_first_r} :
                       reg_hit(haddr, IDX_CHAR_SECOND) ? {pe_second_r, code_second_r} :
                       reg_hit(haddr, IDX_CTRL_ONE) ? c1_read :
                       reg_hit(haddr, IDX_CTRL_TWO) ? {ctrl_two_r[7:3], cmp_mirror} :
                       reg_hit(haddr, IDX_STATUS) ? status_val : 8'h00;

  // ahb slave: zero wait states, read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= BUS_ZERO;
      hrdata_r <= BUS_ZERO;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      wr_addr_r <= addr_phase ? haddr : wr_addr_r;
      hrdata_r <= rd_take ? {24'h000000, rd_byte} : BUS_ZERO;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  // analog and display controls, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
      ref_on_r <= 1'b0;
      clamp_off_r <= 1'b0;
      display_field_r <= 1'b0;
    end else begin
      irq_r <= data_sampled_flag_r && irq_en;
      ref_on_r <= ctrl_one_r[C1_ENABLE];
      clamp_off_r <= slicer_test_mode ? ctrl_one_r[C1_CLAMP] : vblank_r;
      display_field_r <= field_now_r;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign sample_irq = irq_r;
  assign slice_ref_on = ref_on_r;
  assign slice_level = ctrl_two_r[C2_LEVEL_LSB +: 2];
  assign clamp_off = clamp_off_r;
  assign display_field = display_field_r;

endmodule : ccds_core

// File: hw/ccds_pkg.sv
// Purpose: constants, register map and state codes of the caption data slicer core
// Assumes: hclk is the 10 MHz clock derived from the line-locked pll
// Notes: register indices are word indices; byte address is four times the index
package ccds_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RUNIN_DELAY_NS = 24000;
  localparam int RUNIN_WIN_NS = 8000;
  localparam int VS_DELAY_NS = 12000;
  localparam int BIT_PERIOD_NS = 1990;
  localparam int START_TMO_NS = 30000;
  localparam int PW_BASE_NS = 8000;
  localparam int PW_STEP_NS = 2000;
  localparam int RUNIN_DELAY_CYC = (RUNIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RUNIN_WIN_CYC = RUNIN_WIN_NS / CLK_PERIOD_NS;
  localparam int VS_DELAY_CYC = (VS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_CYC = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FIRST_SAMPLE_CYC = (3 * BIT_PERIOD_NS) / (2 * CLK_PERIOD_NS);
  localparam int START_TMO_CYC = START_TMO_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 12;
  localparam int PWC_W = 8;
  // register indices
  localparam logic [7:0] IDX_CHAR_FIRST = 8'h47;
  localparam logic [7:0] IDX_CHAR_SECOND = 8'h48;
  localparam logic [7:0] IDX_CTRL_ONE = 8'h49;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h4A;
  localparam logic [7:0] IDX_STATUS = 8'h4B;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  // control one fields
  localparam int C1_IRQ_EN = 7;
  localparam int C1_ENABLE = 6;
  localparam int C1_VVERIFY = 5;
  localparam int C1_LINE_LSB = 1;
  localparam int C1_CLAMP = 0;
  // control two fields
  localparam int C2_LEVEL_LSB = 6;
  localparam int C2_PW_LSB = 4;
  localparam int C2_VDELAY = 3;
  // status fields
  localparam int SR_FLAG = 7;
  localparam int SR_OVR = 6;
  localparam int SR_FIRST_FIELD_INDICATOR = 5;
  localparam int SR_SYNC = 4;
  localparam int SR_VPS = 3;
  // line numbers, then counts and bus constants
  localparam logic [4:0] FIRST_TARGET_LINE = 5'h0E;
  localparam logic [4:0] VP_LINE = 5'h04;
  localparam logic [4:0] VBLANK_END_LINE = 5'h09;
  localparam logic [1:0] RUNIN_SAT = 2'h3;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

  typedef enum logic [6:0] {
    CCDS_S_VWAIT = 7'h01,
    CCDS_S_LINE = 7'h02,
    CCDS_S_SYNCW = 7'h04,
    CCDS_S_DELAY = 7'h08,
    CCDS_S_RUNIN = 7'h10,
    CCDS_S_START = 7'h20,
    CCDS_S_BITS = 7'h40
  } ccds_state_t;
endpackage : ccds_pkg

// File: test/ccds_checker.sv
// Purpose: bus and control output checks for ccds_core
// Assumes: one slave, so hready is the core's own hreadyout
// Notes: control shadows are rebuilt from observed bus writes only
`timescale 1ns/1ps
module ccds_checker
  import ccds_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic slicer_test_mode,
  input wire logic sample_irq,
  input wire logic slice_ref_on,
  input wire logic [1:0] slice_level,
  input wire logic clamp_off
);
  logic ap_wr_r;
  logic ap_rd_r;
  logic [7:0] ap_idx_r;
  logic [7:0] c1_r;
  logic [1:0] lvl_r;
  logic clamp_r;
  // decode of the remembered address phase
  wire logic take = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire logic st_wr = ap_wr_r && (ap_idx_r == IDX_STATUS);
  wire logic c1_wr = ap_wr_r && (ap_idx_r == IDX_CTRL_ONE);
  wire logic c2_wr = ap_wr_r && (ap_idx_r == IDX_CTRL_TWO);
  // zero wait states, so the data phase is always the very next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'h0;
      ap_rd_r <= 1'h0;
      ap_idx_r <= 8'h00;
    end else begin
      ap_wr_r <= take && hwrite;
      ap_rd_r <= take && !hwrite;
      ap_idx_r <= haddr[9:2];
    end
  end
  // shadows; the clamp bit ignores writes made outside test mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c1_r <= CTRL_ONE_RST;
      lvl_r <= 2'h0;
      clamp_r <= 1'h0;
    end else begin
      if (c1_wr) c1_r <= hwdata[7:0];
      if (c2_wr) lvl_r <= hwdata[7:6];
      if (c1_wr && slicer_test_mode) clamp_r <= hwdata[0];
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_irq_gate; sample_irq |-> $past(c1_r[C1_IRQ_EN]); endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
  property p_irq_hold; sample_irq && c1_r[C1_IRQ_EN] && !$past(st_wr) |=> sample_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
  property p_irq_clear; st_wr |-> ##2 !sample_irq; endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq kept after clear");
  property p_ref_on; slice_ref_on == $past(c1_r[C1_ENABLE]); endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference not following enable");
  property p_clamp; $past(slicer_test_mode) |-> clamp_off == $past(clamp_r); endproperty
  a_clamp: assert property (p_clamp) else $error("clamp not following test bit");
  property p_level; slice_level == lvl_r; endproperty
  a_level: assert property (p_level) else $error("level select mismatch");
  property p_rd_idle; !ap_rd_r |-> hrdata == BUS_ZERO; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
endmodule : ccds_checker

// File: test/ccds_video_model.sv
// Purpose: video source model: sliced sync and data, vsync and pll hsync
// Assumes: one field per call; the target line is reached after lines hsync edges
// Notes: line period shortened to fit the run; hsync stands still between fields
`timescale 1ns/1ps
module ccds_video_model #(
  parameter int LINE_CYC = 700
) (
  input wire logic hclk,
  output logic sync_sliced,
  output logic data_sliced,
  output logic vsync,
  output logic hsync_pll
);
  // target line: run-in pulses, start bit at 340, then bits lsb first, 19 cycles each
  function automatic logic dval(input int c, input logic [15:0] b, input int n);
    if (c >= 250 && c < 250 + 10 * n) return (c % 10) < 5;
    if (c >= 340 && c < 360) return 1'h1;
    if (c >= 360 && c < 664) return b[(c - 360) / 19];
    return 1'h0;
  endfunction : dval
  // quiet lines until the first field is sent
  initial begin
    sync_sliced = 1'h0;
    data_sliced = 1'h0;
    vsync = 1'h0;
    hsync_pll = 1'h0;
  end
  // wide pulse, then one pass per line; vs_at below zero leaves vsync out
  task automatic send_field(input int lines, input logic [15:0] b, input int n, input int vs_at);
    sync_sliced <= 1'h1;
    repeat (150) @(posedge hclk);
    sync_sliced <= 1'h0;
    for (int ln = 1; ln <= lines; ln++) begin
      for (int c = 0; c < LINE_CYC; c++) begin
        @(posedge hclk);
        hsync_pll <= c < LINE_CYC / 2;
        sync_sliced <= c >= 2 && c < 49;
        vsync <= vs_at >= 0 && ln == 1 && c >= vs_at && c < vs_at + 30;
        data_sliced <= ln == lines && dval(c, b, n);
      end
    end
  endtask : send_field
endmodule : ccds_video_model

// File: test/test_caption_data_slicer_core.sv
// Purpose: self-checking bench for ccds_core
// Assumes: 10 MHz hclk; the video model drives the link side
// Notes: a field takes some 7000 cycles, line 29 some 17500
`timescale 1ns/1ps
module test_caption_data_slicer_core import ccds_pkg::*;;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic sync_sliced;
  logic data_sliced;
  logic vsync;
  logic hsync_pll;
  logic pll_enable;
  logic slicer_test_mode;
  logic sample_irq;
  logic slice_ref_on;
  logic [1:0] slice_level;
  logic clamp_off;
  logic display_field;
  int bad_count = 0;
  int checks = 0;
  // one slave, so its hreadyout is the bus hready
  ccds_core dut (.*, .hready(hreadyout));
  ccds_video_model vid (.*);
  // clock
  initial begin
    hclk = 1'h0;
    forever #50 hclk = ~hclk;
  end
  task automatic end_of_test;
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // no cycle count here: only the watchdog ends a wait that never sees ready
  task automatic wait_ready;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'h1);
  endtask : wait_ready
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_ready;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready;
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'h1, idx, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] x;
    bus(1'h0, idx, 8'h00, x);
    check(x, {24'h0, exp});
  endtask : rd
  // character byte as held: parity flag on top when the byte is not odd
  function automatic logic [7:0] ch(input logic [7:0] b);
    return {~(^b), b[6:0]};
  endfunction : ch
  task automatic t_reset;
    check(32'(slice_ref_on), 32'h0);
    rd(IDX_CTRL_ONE, 8'h00);
    rd(IDX_CTRL_TWO, 8'h00);
    rd(IDX_STATUS, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
  endtask : t_reset
  // clamp bit is dead outside test mode, live inside it
  task automatic t_clamp;
    wr(IDX_CTRL_ONE, 8'h01);
    rd(IDX_CTRL_ONE, 8'h00);
    slicer_test_mode <= 1'h1;
    wr(IDX_CTRL_ONE, 8'h01);
    rd(IDX_CTRL_ONE, 8'h01);
    check(32'(clamp_off), 32'h1);
    wr(IDX_CTRL_ONE, 8'h00);
    slicer_test_mode <= 1'h0;
  endtask : t_clamp
  // field one: four run-in edges saturate at three, second byte has even parity
  task automatic t_capture;
    wr(IDX_CTRL_ONE, 8'hC0);
    vid.send_field(10, 16'h03C1, 4, 100);
    check(32'(slice_ref_on), 32'h1);
    check(32'(sample_irq), 32'h1);
    check(32'(display_field), 32'h1);
    rd(IDX_STATUS, 8'hAB);
    rd(IDX_CHAR_FIRST, ch(8'hC1));
    rd(IDX_CHAR_SECOND, ch(8'h03));
  endtask : t_capture
  // field two lands before the host clears: overrun, then one status write
  task automatic t_overrun;
    vid.send_field(10, 16'h552A, 2, 400);
    check(32'(display_field), 32'h0);
    rd(IDX_STATUS, 8'hCB);
    wr(IDX_CHAR_FIRST, 8'h00);
    rd(IDX_CHAR_FIRST, ch(8'h2A));
    rd(IDX_CHAR_SECOND, ch(8'h55));
    wr(IDX_STATUS, 8'h00);
    rd(IDX_STATUS, 8'h08);
    rd(IDX_CHAR_SECOND, 8'h55);
    check(32'(sample_irq), 32'h0);
  endtask : t_overrun
  // verification on and no vsync: the field is dropped; live sync read mid wide pulse
  task automatic t_abort;
    wr(IDX_CTRL_ONE, 8'h60);
    fork
      vid.send_field(10, 16'h1234, 3, -1);
      begin
        repeat (20) @(posedge hclk);
        rd(IDX_STATUS, 8'h18);
      end
    join
    rd(IDX_STATUS, 8'h00);
  endtask : t_abort
  // line 29, widest pulse code; the delay moves vsync into the low half of hsync
  task automatic t_line29;
    wr(IDX_CTRL_TWO, 8'hB8);
    rd(IDX_CTRL_TWO, 8'hB8);
    check(32'(slice_level), 32'h2);
    wr(IDX_CTRL_ONE, 8'h7E);
    vid.send_field(25, 16'hE01F, 1, 300);
    rd(IDX_STATUS, 8'h89);
    rd(IDX_CHAR_FIRST, ch(8'h1F));
    rd(IDX_CHAR_SECOND, ch(8'hE0));
    check(32'(sample_irq), 32'h0);
    wr(IDX_STATUS, 8'h00);
  endtask : t_line29
  // slicer enabled but pll off: nothing may be sampled
  task automatic t_pll;
    logic [31:0] x;
    wr(IDX_CTRL_ONE, 8'h40);
    pll_enable <= 1'h0;
    vid.send_field(10, 16'h1111, 3, 100);
    bus(1'h0, IDX_STATUS, 8'h00, x);
    check(x & 32'h80, 32'h0);
    pll_enable <= 1'h1;
  endtask : t_pll
  // watchdog, well above the planned fifty thousand cycles
  initial begin
    repeat (90000) @(posedge hclk);
    bad_count++;
    end_of_test;
  end
  // main sequence
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pll_enable = 1'h1;
    slicer_test_mode = 1'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset;
    t_clamp;
    t_capture;
    t_overrun;
    t_abort;
    t_line29;
    t_pll;
    end_of_test;
  end
endmodule : test_caption_data_slicer_core
bind ccds_core ccds_checker chk (.*);
